/* src/rgpl_pkg.sv */
// constants and types shared by the rgmii port pin logic
`default_nettype none
package rgpl_pkg;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 8;
  localparam int TXCLK_1000_PERIOD_NS = 8;
  localparam int TXCLK_100_PERIOD_NS  = 40;
  localparam int TXCLK_10_PERIOD_NS   = 400;
  localparam logic [5:0] CYC_1000 = 6'(TXCLK_1000_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [5:0] CYC_100  = 6'(TXCLK_100_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [5:0] CYC_10   = 6'(TXCLK_10_PERIOD_NS / CLK_PERIOD_NS);

  // -------------------------------------------------------------------------
  // encodings and reset values
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RGPL_SPD_10   = 2'h0,
    RGPL_SPD_100  = 2'h1,
    RGPL_SPD_1000 = 2'h3
  } rgpl_speed_t;

  localparam logic       LED_SEL_TX  = 1'h0;
  localparam logic       LED_SEL_LED = 1'h1;
  localparam logic [3:0] NIBBLE_RST  = 4'h0;
  localparam logic [7:0] BYTE_RST    = 8'h0;
  localparam logic [5:0] CNT_RST     = 6'h0;

  function automatic logic [5:0] rgpl_period_cycles(input rgpl_speed_t spd);
    case (spd)
      RGPL_SPD_1000: rgpl_period_cycles = CYC_1000;
      RGPL_SPD_100:  rgpl_period_cycles = CYC_100;
      default:       rgpl_period_cycles = CYC_10;
    endcase
  endfunction
endpackage
`default_nettype wire

/* src/rgpl_rx_lane.sv */
// one rgmii receive lane, sampled by the core clock
`default_nettype none
module rgpl_rx_lane (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 rx_clock_in,
  input  wire logic [3:0]           rx_nibble_in,
  input  wire logic                 rx_valid_in,
  input  wire rgpl_pkg::rgpl_speed_t speed_in,
  output logic [7:0]                rx_byte_out,
  output logic                      rx_byte_valid_out,
  output logic                      rx_byte_error_out,
  output logic                      rx_frame_out
);
  import rgpl_pkg::*;

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic       clk_prev_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg     <= 6'h00;
      sync_reg     <= 6'h00;
      clk_prev_reg <= 1'h0;
    end else begin
      meta_reg     <= {rx_clock_in, rx_valid_in, rx_nibble_in};
      sync_reg     <= meta_reg;
      clk_prev_reg <= sync_reg[5];
    end
  end

  logic       rise;
  logic       fall;
  logic [3:0] nib;
  logic       ctl;
  assign rise = sync_reg[5] & ~clk_prev_reg;
  assign fall = ~sync_reg[5] & clk_prev_reg;
  assign nib  = sync_reg[3:0];
  assign ctl  = sync_reg[4];

  // -------------------------------------------------------------------------
  // nibble capture and byte assembly
  // -------------------------------------------------------------------------
  logic [3:0] low_reg;
  logic       dv_reg;
  logic       phase_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_reg           <= NIBBLE_RST;
      dv_reg            <= 1'h0;
      phase_reg         <= 1'h0;
      rx_byte_out       <= BYTE_RST;
      rx_byte_valid_out <= 1'h0;
      rx_byte_error_out <= 1'h0;
      rx_frame_out      <= 1'h0;
    end else begin
      rx_byte_valid_out <= 1'h0;
      if (speed_in == RGPL_SPD_1000) begin
        phase_reg <= 1'h0;
        if (rise) begin
          low_reg      <= nib;
          dv_reg       <= ctl;
          rx_frame_out <= ctl;
        end
        if (fall && dv_reg) begin
          rx_byte_out       <= {nib, low_reg};
          rx_byte_valid_out <= 1'h1;
          rx_byte_error_out <= dv_reg ^ ctl;
        end
      end else if (rise) begin
        rx_frame_out <= ctl;
        if (!ctl) begin
          phase_reg <= 1'h0;
        end else if (!phase_reg) begin
          low_reg   <= nib;
          phase_reg <= 1'h1;
        end else begin
          rx_byte_out       <= {nib, low_reg};
          rx_byte_valid_out <= 1'h1;
          rx_byte_error_out <= 1'h0;
          phase_reg         <= 1'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* src/rgpl_top.sv */
// pin logic of the management and uplink rgmii ports
`default_nettype none
module rgpl_top (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  // management port user side
  input  wire rgpl_pkg::rgpl_speed_t mgmt_speed_in,
  input  wire logic [7:0]            mgmt_tx_byte_in,
  input  wire logic                  mgmt_tx_en_in,
  input  wire logic                  mgmt_tx_er_in,
  output logic                       mgmt_tx_take_out,
  output logic [7:0]                 mgmt_rx_byte_out,
  output logic                       mgmt_rx_byte_valid_out,
  output logic                       mgmt_rx_byte_error_out,
  output logic                       mgmt_rx_frame_out,
  // management port pins
  input  wire logic                  mgmt_port_rx_clock_in,
  input  wire logic [3:0]            mgmt_port_rx_nibble_in,
  input  wire logic                  mgmt_port_rx_valid_in,
  output logic                       mgmt_port_tx_clock_rise_out,
  output logic                       mgmt_port_tx_clock_fall_out,
  output logic [3:0]                 mgmt_port_tx_nibble_rise_out,
  output logic [3:0]                 mgmt_port_tx_nibble_fall_out,
  output logic                       mgmt_port_tx_enable_rise_out,
  output logic                       mgmt_port_tx_enable_fall_out,
  // uplink user side
  input  wire rgpl_pkg::rgpl_speed_t uplink_speed_in,
  input  wire logic [7:0]            uplink_tx_byte_in,
  input  wire logic                  uplink_tx_en_in,
  input  wire logic                  uplink_tx_er_in,
  output logic                       uplink_tx_take_out,
  input  wire logic [5:0]            uplink_led_on_in,
  output logic [7:0]                 uplink_rx_byte_out,
  output logic                       uplink_rx_byte_valid_out,
  output logic                       uplink_rx_byte_error_out,
  output logic                       uplink_rx_frame_out,
  // uplink pins
  input  wire logic                  uplink_led_select_in,
  input  wire logic                  uplink_rx_clock_in,
  input  wire logic [3:0]            uplink_rx_nibble_in,
  input  wire logic                  uplink_rx_valid_in,
  output logic                       uplink_tx_clock_or_led_f_rise_out,
  output logic                       uplink_tx_clock_or_led_f_fall_out,
  output logic [3:0]                 uplink_tx_bits_or_led_a_to_d_rise_out,
  output logic [3:0]                 uplink_tx_bits_or_led_a_to_d_fall_out,
  output logic                       uplink_tx_enable_or_led_e_rise_out,
  output logic                       uplink_tx_enable_or_led_e_fall_out
);
  import rgpl_pkg::*;

  // -------------------------------------------------------------------------
  // receive lanes
  // -------------------------------------------------------------------------
  // the far ends own the receive clocks and drive valid from their enable
  rgpl_rx_lane u_mgmt_rx (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .rx_clock_in       (mgmt_port_rx_clock_in),
    .rx_nibble_in      (mgmt_port_rx_nibble_in),
    .rx_valid_in       (mgmt_port_rx_valid_in),
    .speed_in          (mgmt_speed_in),
    .rx_byte_out       (mgmt_rx_byte_out),
    .rx_byte_valid_out (mgmt_rx_byte_valid_out),
    .rx_byte_error_out (mgmt_rx_byte_error_out),
    .rx_frame_out      (mgmt_rx_frame_out)
  );

  rgpl_rx_lane u_uplink_rx (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .rx_clock_in       (uplink_rx_clock_in),
    .rx_nibble_in      (uplink_rx_nibble_in),
    .rx_valid_in       (uplink_rx_valid_in),
    .speed_in          (uplink_speed_in),
    .rx_byte_out       (uplink_rx_byte_out),
    .rx_byte_valid_out (uplink_rx_byte_valid_out),
    .rx_byte_error_out (uplink_rx_byte_error_out),
    .rx_frame_out      (uplink_rx_frame_out)
  );

  // -------------------------------------------------------------------------
  // led select strap synchroniser
  // -------------------------------------------------------------------------
  logic sel_meta_reg;
  logic sel_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_meta_reg <= LED_SEL_TX;
      sel_reg      <= LED_SEL_TX;
    end else begin
      sel_meta_reg <= uplink_led_select_in;
      sel_reg      <= sel_meta_reg;
    end
  end

  // -------------------------------------------------------------------------
  // transmit lanes, index 0 management, index 1 uplink
  // -------------------------------------------------------------------------
  // each output is a rise/fall pair for a ddr output cell; one core cycle
  // is two half slots, so a 4 ns resolution covers all three clock rates
  rgpl_speed_t spd_a [2];
  logic [7:0]  byte_a [2];
  logic        en_a [2];
  logic        er_a [2];
  logic        take_a [2];
  logic        ck_r_a [2];
  logic        ck_f_a [2];
  logic [3:0]  nb_r_a [2];
  logic [3:0]  nb_f_a [2];
  logic        te_r_a [2];
  logic        te_f_a [2];

  assign spd_a[0]  = mgmt_speed_in;
  assign spd_a[1]  = uplink_speed_in;
  assign byte_a[0] = mgmt_tx_byte_in;
  assign byte_a[1] = uplink_tx_byte_in;
  assign en_a[0]   = mgmt_tx_en_in;
  assign en_a[1]   = uplink_tx_en_in;
  assign er_a[0]   = mgmt_tx_er_in;
  assign er_a[1]   = uplink_tx_er_in;

  for (genvar i = 0; i < 2; i++) begin : g_tx
    logic [5:0] cnt_reg;
    logic [5:0] period;
    logic       upper_pend_reg;
    logic [3:0] upper_reg;
    logic       led_mode;
    logic       ck_r;
    logic       ck_f;
    assign period   = rgpl_period_cycles(spd_a[i]);
    assign led_mode = (i == 1) && (sel_reg == LED_SEL_LED);
    // clock high during the first half of the period, counted in half slots
    assign ck_r     = {cnt_reg, 1'h0} < {1'h0, period};
    assign ck_f     = {cnt_reg, 1'h1} < {1'h0, period};

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        cnt_reg <= CNT_RST;
      end else if (cnt_reg >= period - 6'h01) begin
        cnt_reg <= CNT_RST;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        ck_r_a[i] <= 1'h0;
        ck_f_a[i] <= 1'h0;
      end else if (led_mode) begin
        ck_r_a[i] <= ~uplink_led_on_in[5];
        ck_f_a[i] <= ~uplink_led_on_in[5];
      end else begin
        ck_r_a[i] <= ck_r;
        ck_f_a[i] <= ck_f;
      end
    end

    // data changes only with the period start, i.e. the rising clock edge;
    // in led mode the lane keeps counting so a switch back is glitch free
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        upper_pend_reg <= 1'h0;
        upper_reg      <= NIBBLE_RST;
        take_a[i]      <= 1'h0;
        nb_r_a[i]      <= NIBBLE_RST;
        nb_f_a[i]      <= NIBBLE_RST;
        te_r_a[i]      <= 1'h0;
        te_f_a[i]      <= 1'h0;
      end else begin
        take_a[i] <= 1'h0;
        if (led_mode) begin
          upper_pend_reg <= 1'h0;
          nb_r_a[i]      <= ~uplink_led_on_in[3:0];
          nb_f_a[i]      <= ~uplink_led_on_in[3:0];
          te_r_a[i]      <= ~uplink_led_on_in[4];
          te_f_a[i]      <= ~uplink_led_on_in[4];
        end else if (cnt_reg == CNT_RST) begin
          if (spd_a[i] == RGPL_SPD_1000) begin
            upper_pend_reg <= 1'h0;
            take_a[i]      <= 1'h1;
            nb_r_a[i]      <= byte_a[i][3:0];
            nb_f_a[i]      <= byte_a[i][7:4];
            te_r_a[i]      <= en_a[i];
            te_f_a[i]      <= en_a[i] ^ er_a[i];
          end else if (upper_pend_reg) begin
            upper_pend_reg <= 1'h0;
            nb_r_a[i]      <= upper_reg;
            nb_f_a[i]      <= upper_reg;
          end else begin
            // low nibble first, high nibble held for the next period
            upper_pend_reg <= en_a[i];
            upper_reg      <= byte_a[i][7:4];
            take_a[i]      <= 1'h1;
            nb_r_a[i]      <= byte_a[i][3:0];
            nb_f_a[i]      <= byte_a[i][3:0];
            te_r_a[i]      <= en_a[i];
            te_f_a[i]      <= en_a[i] ^ er_a[i];
          end
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // take strobes and pin outputs
  // -------------------------------------------------------------------------
  assign mgmt_tx_take_out                      = take_a[0];
  assign mgmt_port_tx_clock_rise_out           = ck_r_a[0];
  assign mgmt_port_tx_clock_fall_out           = ck_f_a[0];
  assign mgmt_port_tx_nibble_rise_out          = nb_r_a[0];
  assign mgmt_port_tx_nibble_fall_out          = nb_f_a[0];
  assign mgmt_port_tx_enable_rise_out          = te_r_a[0];
  assign mgmt_port_tx_enable_fall_out          = te_f_a[0];
  assign uplink_tx_take_out                    = take_a[1];
  assign uplink_tx_clock_or_led_f_rise_out     = ck_r_a[1];
  assign uplink_tx_clock_or_led_f_fall_out     = ck_f_a[1];
  assign uplink_tx_bits_or_led_a_to_d_rise_out = nb_r_a[1];
  assign uplink_tx_bits_or_led_a_to_d_fall_out = nb_f_a[1];
  assign uplink_tx_enable_or_led_e_rise_out    = te_r_a[1];
  assign uplink_tx_enable_or_led_e_fall_out    = te_f_a[1];
endmodule
`default_nettype wire

/* tb/rgpl_top_sva.sv */
// concurrent checks on the top ports of the rgmii port pin logic
`default_nettype none
module rgpl_top_sva (
  input wire logic                  clk_in,
  input wire logic                  resetn_in,
  input wire rgpl_pkg::rgpl_speed_t mgmt_speed_in,
  input wire logic [7:0]            mgmt_tx_byte_in,
  input wire logic                  mgmt_tx_en_in,
  input wire logic                  mgmt_tx_er_in,
  input wire logic                  mgmt_tx_take_out,
  input wire logic                  uplink_tx_take_out,
  input wire logic                  mgmt_port_tx_clock_rise_out,
  input wire logic                  mgmt_port_tx_clock_fall_out,
  input wire logic [3:0]            mgmt_port_tx_nibble_rise_out,
  input wire logic [3:0]            mgmt_port_tx_nibble_fall_out,
  input wire logic                  mgmt_port_tx_enable_rise_out,
  input wire logic                  mgmt_port_tx_enable_fall_out,
  input wire logic                  uplink_led_select_in,
  input wire logic [5:0]            uplink_led_on_in,
  input wire logic                  uplink_tx_clock_or_led_f_rise_out,
  input wire logic [3:0]            uplink_tx_bits_or_led_a_to_d_rise_out,
  input wire logic                  uplink_tx_enable_or_led_e_rise_out,
  input wire logic                  mgmt_rx_byte_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import rgpl_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence gig_take_s;
    mgmt_tx_take_out && mgmt_speed_in == RGPL_SPD_1000 && $past(mgmt_speed_in) == RGPL_SPD_1000;
  endsequence
  sequence fast_take_s;
    mgmt_tx_take_out && $past(mgmt_tx_en_in) && mgmt_speed_in == RGPL_SPD_100
      && $past(mgmt_speed_in) == RGPL_SPD_100;
  endsequence
  // select must have crossed the synchroniser before the pins follow it
  sequence led_steady_s;
    uplink_led_select_in[*5] ##0 $stable(uplink_led_on_in)
      && $past(uplink_led_on_in, 2) == uplink_led_on_in;
  endsequence
  gig_pairing_a: assert property (gig_take_s |->
    mgmt_port_tx_nibble_rise_out == 4'($past(mgmt_tx_byte_in))
    && mgmt_port_tx_nibble_fall_out == 4'($past(mgmt_tx_byte_in) >> 4))
    else $error("gigabit nibble pair wrong");
  gig_enable_a: assert property (gig_take_s |->
    mgmt_port_tx_enable_rise_out == $past(mgmt_tx_en_in)
    && mgmt_port_tx_enable_fall_out == ($past(mgmt_tx_en_in) ^ $past(mgmt_tx_er_in)))
    else $error("gigabit enable pair wrong");
  gig_clock_a: assert property (gig_take_s |->
    mgmt_port_tx_clock_rise_out && !mgmt_port_tx_clock_fall_out)
    else $error("gigabit clock halves wrong");
  fast_clock_a: assert property (fast_take_s |->
    (mgmt_port_tx_clock_rise_out && mgmt_port_tx_clock_fall_out)[*2]
    ##1 (mgmt_port_tx_clock_rise_out && !mgmt_port_tx_clock_fall_out)
    ##1 (!mgmt_port_tx_clock_rise_out && !mgmt_port_tx_clock_fall_out)[*2])
    else $error("25 MHz clock shape wrong");
  fast_high_nibble_a: assert property (fast_take_s |-> ##5
    mgmt_port_tx_nibble_rise_out == 4'($past(mgmt_tx_byte_in, 6) >> 4)
    && mgmt_port_tx_nibble_fall_out == mgmt_port_tx_nibble_rise_out)
    else $error("high nibble period wrong");
  take_spacing_a: assert property (fast_take_s |=> !mgmt_tx_take_out[*8])
    else $error("take too soon at 100M");
  led_take_a: assert property (uplink_led_select_in[*5] |-> !uplink_tx_take_out)
    else $error("byte taken in led mode");
  led_pins_a: assert property (led_steady_s |->
    uplink_tx_bits_or_led_a_to_d_rise_out == ~uplink_led_on_in[3:0]
    && uplink_tx_enable_or_led_e_rise_out == ~uplink_led_on_in[4]
    && uplink_tx_clock_or_led_f_rise_out == ~uplink_led_on_in[5])
    else $error("led pins not active low");
  rx_pulse_a: assert property (mgmt_rx_byte_valid_out && mgmt_speed_in != RGPL_SPD_1000
    |=> !mgmt_rx_byte_valid_out) else $error("receive byte pulse too long");
endmodule
bind rgpl_top rgpl_top_sva i_rgpl_top_sva (.*);
`default_nettype wire

/* tb/rgpl_far_mac.sv */
// far-end mac model driving one rgmii receive lane
`default_nettype none
module rgpl_far_mac (
  output logic       rx_clock_out,
  output logic [3:0] rx_nibble_out,
  output logic       rx_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // an rgmii receive clock runs free, also between frames
  initial begin
    rx_clock_out = 1'b0;
    rx_nibble_out = 4'hA;
    rx_valid_out = 1'b0;
    forever #62.5 rx_clock_out = ~rx_clock_out;
  end
  task automatic send(input logic [7:0] first, input int n, input bit gig);
    logic [7:0] b;
    @(negedge rx_clock_out);
    for (int i = 0; i < n; i++) begin
      b = first + 8'(i);
      #31 rx_nibble_out = b[3:0];
      rx_valid_out = 1'b1;
      if (gig) @(posedge rx_clock_out);
      else @(negedge rx_clock_out);
      #31 rx_nibble_out = b[7:4];
      @(negedge rx_clock_out);
    end
    // a stale nibble must never look like fresh data
    #31 rx_valid_out = 1'b0;
    rx_nibble_out = ~rx_nibble_out;
  endtask
endmodule
`default_nettype wire

/* tb/test_rgpl_top.sv */
// self-checking bench for the rgmii port pin logic
`default_nettype none
module test_rgpl_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rgpl_pkg::*;
  logic                 clk_in;
  logic                 resetn_in;
  logic                 led_sel;
  logic [5:0]           led_on;
  rgpl_speed_t          spd [2];
  logic [1:0][7:0]      tx_byte;
  logic [1:0]           tx_en;
  logic [1:0]           tx_er;
  wire logic [1:0]      take, ckr, ckf, enr, enf, rxv, rxe, rxf, rck, rv;
  wire logic [1:0][3:0] nr, nf, rnib;
  wire logic [1:0][7:0] rxb;
  logic [7:0]           mq [$];
  logic [7:0]           uq [$];
  int                   err_count;
  int                   total_checks;
  int                   rxe_seen;
  rgpl_top i_rgpl_top (.clk_in(clk_in), .resetn_in(resetn_in), .mgmt_speed_in(spd[0]),
    .mgmt_tx_byte_in(tx_byte[0]), .mgmt_tx_en_in(tx_en[0]), .mgmt_tx_er_in(tx_er[0]),
    .mgmt_tx_take_out(take[0]), .mgmt_rx_byte_out(rxb[0]), .mgmt_rx_byte_valid_out(rxv[0]),
    .mgmt_rx_byte_error_out(rxe[0]), .mgmt_rx_frame_out(rxf[0]),
    .mgmt_port_rx_clock_in(rck[0]), .mgmt_port_rx_nibble_in(rnib[0]),
    .mgmt_port_rx_valid_in(rv[0]), .mgmt_port_tx_clock_rise_out(ckr[0]),
    .mgmt_port_tx_clock_fall_out(ckf[0]), .mgmt_port_tx_nibble_rise_out(nr[0]),
    .mgmt_port_tx_nibble_fall_out(nf[0]), .mgmt_port_tx_enable_rise_out(enr[0]),
    .mgmt_port_tx_enable_fall_out(enf[0]), .uplink_speed_in(spd[1]),
    .uplink_tx_byte_in(tx_byte[1]), .uplink_tx_en_in(tx_en[1]), .uplink_tx_er_in(tx_er[1]),
    .uplink_tx_take_out(take[1]), .uplink_led_on_in(led_on), .uplink_rx_byte_out(rxb[1]),
    .uplink_rx_byte_valid_out(rxv[1]), .uplink_rx_byte_error_out(rxe[1]),
    .uplink_rx_frame_out(rxf[1]), .uplink_led_select_in(led_sel),
    .uplink_rx_clock_in(rck[1]), .uplink_rx_nibble_in(rnib[1]), .uplink_rx_valid_in(rv[1]),
    .uplink_tx_clock_or_led_f_rise_out(ckr[1]), .uplink_tx_clock_or_led_f_fall_out(ckf[1]),
    .uplink_tx_bits_or_led_a_to_d_rise_out(nr[1]), .uplink_tx_bits_or_led_a_to_d_fall_out(nf[1]),
    .uplink_tx_enable_or_led_e_rise_out(enr[1]), .uplink_tx_enable_or_led_e_fall_out(enf[1]));
  rgpl_far_mac i_rgpl_far_mac_mgmt (.rx_clock_out(rck[0]), .rx_nibble_out(rnib[0]),
    .rx_valid_out(rv[0]));
  rgpl_far_mac i_rgpl_far_mac_uplink (.rx_clock_out(rck[1]), .rx_nibble_out(rnib[1]),
    .rx_valid_out(rv[1]));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    if (rxv[0] === 1'b1) mq.push_back(rxb[0]);
    if (rxv[1] === 1'b1) uq.push_back(rxb[1]);
    // clean frames must never flag a receive error
    if ((rxv & rxe) !== 2'h0) rxe_seen++;
  end
  // ---------------------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // both ports transmit side by side; error toggles per byte
  task automatic run_tx(input rgpl_speed_t sp, input int n);
    int got [2];
    int last [2];
    int gap;
    got = '{0, 0};
    last = '{0, 0};
    gap = (sp == RGPL_SPD_1000) ? 1 : 2 * int'((sp == RGPL_SPD_100) ? CYC_100 : CYC_10);
    spd = '{sp, sp};
    tx_en = 2'h3;
    tx_byte = {8'h3C, 8'hA5};
    for (int c = 0; c < n * gap * 2 + 40 && (got[0] < n || got[1] < n); c++) begin
      @(negedge clk_in);
      for (int p = 0; p < 2; p++) if (take[p] === 1'b1 && got[p] < n) begin
        if (got[p] > 0) check("take spacing", 8'(c - last[p]), 8'(gap));
        if (sp == RGPL_SPD_1000) begin
          check("gig nibbles", {nf[p], nr[p]}, tx_byte[p]);
          check("gig clock", 8'({ckr[p], ckf[p]}), 8'h02);
        end else begin
          check("slow nibbles", {nf[p], nr[p]}, {2{tx_byte[p][3:0]}});
          check("slow clock", 8'({ckr[p], ckf[p]}), 8'h03);
        end
        check("enable pair", 8'({enr[p], enf[p]}), {6'h00, 1'b1, ~tx_er[p]});
        last[p] = c;
        got[p]++;
        tx_byte[p] = tx_byte[p] + 8'h11;
        tx_er[p] = ~tx_er[p];
      end
    end
    check("bytes taken", 8'(got[0] + got[1]), 8'(2 * n));
    tx_en = 2'h0;
    repeat (2 * gap + 10) @(negedge clk_in);
    $display("transmit test done at speed code %0d", sp);
  endtask
  task automatic run_led;
    logic [5:0] pat;
    led_sel = 1'b1;
    tx_en = 2'h3;
    repeat (6) @(negedge clk_in);
    for (int i = 0; i < 4; i++) begin
      pat = (i == 2) ? 6'h3F : (i == 3) ? 6'h00 : 6'h15 << i;
      led_on = pat;
      repeat (3) @(negedge clk_in);
      check("led rise half", {2'h0, ckr[1], enr[1], nr[1]}, {2'h0, ~pat});
      check("led fall half", {2'h0, ckf[1], enf[1], nf[1]}, {2'h0, ~pat});
      check("led mode take", 8'(take[1]), 8'h00);
    end
    led_sel = 1'b0;
    tx_en = 2'h0;
    repeat (6) @(negedge clk_in);
    $display("led test done");
  endtask
  task automatic run_rx(input bit gig);
    mq.delete();
    uq.delete();
    rxe_seen = 0;
    if (gig) begin
      spd = '{RGPL_SPD_1000, RGPL_SPD_1000};
    end else begin
      spd = '{RGPL_SPD_100, RGPL_SPD_100};
    end
    fork
      i_rgpl_far_mac_mgmt.send(8'h30, 4, gig);
      i_rgpl_far_mac_uplink.send(8'hC0, 4, gig);
    join
    repeat (40) @(negedge clk_in);
    check("mgmt rx count", 8'(mq.size()), 8'h04);
    check("uplink rx count", 8'(uq.size()), 8'h04);
    for (int i = 0; i < 4; i++) begin
      if (i < mq.size()) check("mgmt rx byte", mq[i], 8'h30 + 8'(i));
      if (i < uq.size()) check("uplink rx byte", uq[i], 8'hC0 + 8'(i));
    end
    check("frame after end", 8'(rxf), 8'h00);
    check("rx error flags", 8'(rxe_seen), 8'h00);
    $display("receive test done, gigabit %0d", gig);
  endtask
  initial begin
    err_count = 0;
    total_checks = 0;
    resetn_in = 1'b0;
    led_sel = 1'b0;
    led_on = 6'h00;
    tx_byte = '0;
    tx_en = 2'h0;
    tx_er = 2'h0;
    spd = '{RGPL_SPD_1000, RGPL_SPD_1000};
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (2) @(negedge clk_in);
    run_tx(RGPL_SPD_1000, 8);
    run_tx(RGPL_SPD_100, 3);
    run_tx(RGPL_SPD_10, 2);
    run_led();
    run_rx(1'b1);
    run_rx(1'b0);
    tally_and_finish();
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
